// *** src/ccs_pkg.sv ***
// constants, field layouts and types of the channel calibration sequencer
package ccs_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned CAL_SEQ_S    = 10;
  localparam int unsigned CAL_SEQ_CYC  = CAL_SEQ_S * CLK_HZ;
  localparam int unsigned SETTLE_MS    = 50;
  localparam int unsigned SETTLE_CYC   = SETTLE_MS * (CLK_HZ / 1000);
  localparam int unsigned SELFTEST_MS  = 1000;
  localparam int unsigned SELFTEST_CYC = SELFTEST_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W        = 27;

  // ****************************************
  // register indices (byte address is four times the index)
  // ****************************************
  localparam logic [7:0] IDX_ID   = 8'h00;
  localparam logic [7:0] IDX_CSR  = 8'h02;
  localparam logic [7:0] IDX_ERR  = 8'h04;
  localparam logic [7:0] IDX_REV  = 8'h06;
  localparam logic [7:0] IDX_CCR  = 8'h08;
  localparam logic [7:0] IDX_RS03 = 8'h0A;
  localparam logic [7:0] IDX_RS47 = 8'h0C;
  localparam logic [3:0] IDX_CCD_HI = 4'h1;

  // ****************************************
  // control and status word layout
  // ****************************************
  localparam logic [15:0] CSR_RESET     = 16'h0002;
  localparam int unsigned START_BIT     = 0;
  localparam int unsigned RANGE_W       = 4;
  localparam int unsigned ADC_W         = 13;
  localparam logic signed [12:0] FULL_SCALE_CODE = 13'sh0FFF;
  localparam int unsigned GAIN_SHIFT    = 12;

  typedef enum logic [2:0] {
    MODE_SINGLE   = 3'h0,
    MODE_CONT     = 3'h1,
    MODE_OFFS_CAL = 3'h4,
    MODE_GAIN_CAL = 3'h5
  } ccs_mode_e;

  // control bits 7..1 of the control_status_word
  typedef struct packed {
    logic       fault_indicator_off;
    logic       rsvd;
    logic       sw_reset;
    logic       ext_trig_en;
    logic [2:0] mode;
  } ccs_ctrl_s;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SETTLE = 3'h1,
    ST_CONV   = 3'h3,
    ST_STORE  = 3'h2,
    ST_PAD    = 3'h6,
    ST_TEST   = 3'h4
  } ccs_state_e;

endpackage

// *** src/ccs_sequencer.sv ***
// calibration and scan sequencer with avalon-mm register slave
`timescale 1ns/100ps

// Contract
// - 0x0089 write starts offset calibration
// - 0x008B write starts gain calibration
// - only masked channels are calibrated
// - clearing sequence-active flag marks completion
// - compute, store and apply correction factors
// - calibration sequence lasts about ten seconds
// - device inserts input settling delay itself
// - mask 0xFF calibrates all eight channels
// - indicator lit while calibration switch active
// - active flag set during sequence, reset, self-test
// - start bit begins sequence, clears completion
// - mode bits select scan or calibration
module ccs_sequencer #(
  parameter int unsigned CAL_CYCLES      = ccs_pkg::CAL_SEQ_CYC,
  parameter int unsigned SETTLE_CYCLES   = ccs_pkg::SETTLE_CYC,
  parameter int unsigned SELFTEST_CYCLES = ccs_pkg::SELFTEST_CYC,
  parameter logic [15:0] BOARD_ID        = 16'h1234,
  parameter logic [15:0] FW_REVISION     = 16'h0001
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        external_trigger_input_n,
  input  wire logic        cal_switch,
  output logic             status_led,
  output logic             fault_led_on,
  output logic      [2:0]  afe_chan_sel,
  output logic      [3:0]  afe_range,
  output logic             conv_start,
  input  wire logic        conv_done,
  input  wire logic [12:0] conv_data,
  output logic             nvm_we,
  output logic      [3:0]  nvm_addr,
  output logic      [15:0] nvm_wdata
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (CAL_CYCLES < 1 || CAL_CYCLES >= 2**ccs_pkg::CNT_W || SETTLE_CYCLES < 1
      || SETTLE_CYCLES >= 2**ccs_pkg::CNT_W || SELFTEST_CYCLES < 1
      || SELFTEST_CYCLES >= 2**ccs_pkg::CNT_W) begin : g_chk
    $error("ccs_sequencer: cycle count out of counter range");
  end

  localparam logic [26:0] CAL_LAST    = 27'(CAL_CYCLES - 1);
  localparam logic [26:0] SETTLE_LAST = 27'(SETTLE_CYCLES - 1);
  localparam logic [26:0] TEST_LAST   = 27'(SELFTEST_CYCLES - 1);

  // lowest set bit of a pending-channel vector
  function automatic logic [2:0] low_bit(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = 7; i >= 0; i--)
      if (v[i])
        r = 3'(i);
    return r;
  endfunction

  // merge a 16-bit write through the two low byte lanes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ****************************************
  // register bus slave
  // ****************************************
  ccs_pkg::ccs_ctrl_s ctrl, next_ctrl;
  logic        ack, next_ack;
  logic [15:0] channel_select_word, next_ccr;
  logic [15:0] rs03, next_rs03;
  logic [15:0] rs47, next_rs47;
  logic [15:0] err, next_err;
  logic [31:0] rdata, next_rdata;
  logic        fault_q, next_fault_q;
  logic        led_q, next_led_q;
  logic [7:0]  idx;
  logic        wr;
  logic        wr_start;
  logic [15:0] rd16;

  // sequencer state read by the bus
  logic              active;
  logic              stfail;
  logic signed [15:0] ccd [8];

  assign idx             = {2'h0, avs_address[7:2]};
  assign wr              = ack & avs_write;
  // one wait cycle, then the request completes
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign avs_readdata    = rdata;
  assign fault_led_on    = fault_q;
  assign status_led      = led_q;
  assign wr_start = wr & (idx == ccs_pkg::IDX_CSR) & avs_byteenable[0]
                    & avs_writedata[ccs_pkg::START_BIT];

  // read mux and register writes
  always_comb
  begin
    next_ack     = (avs_read | avs_write) & ~ack;
    next_ctrl    = ctrl;
    next_ccr     = channel_select_word;
    next_rs03    = rs03;
    next_rs47    = rs47;
    next_err     = err;
    next_rdata   = rdata;
    next_fault_q = ~ctrl.fault_indicator_off;
    next_led_q   = cal_switch;
    rd16         = 16'h0000;
    case (idx)
      ccs_pkg::IDX_ID:   rd16 = BOARD_ID;
      ccs_pkg::IDX_CSR:  rd16 = {8'h00, ctrl.fault_indicator_off, stfail, ctrl.sw_reset,
                                 ctrl.ext_trig_en, ctrl.mode, active};
      ccs_pkg::IDX_ERR:  rd16 = err;
      ccs_pkg::IDX_REV:  rd16 = FW_REVISION;
      ccs_pkg::IDX_CCR:  rd16 = channel_select_word;
      ccs_pkg::IDX_RS03: rd16 = rs03;
      ccs_pkg::IDX_RS47: rd16 = rs47;
      default:
        if (idx[7:4] == ccs_pkg::IDX_CCD_HI && !idx[0])
          rd16 = ccd[idx[3:1]];
    endcase
    if (avs_read && !ack)
      next_rdata = {16'h0000, rd16};
    if (wr)
    begin
      case (idx)
        ccs_pkg::IDX_CSR:
          if (avs_byteenable[0])
            next_ctrl = ccs_pkg::ccs_ctrl_s'(avs_writedata[7:1]);
        ccs_pkg::IDX_CCR:  next_ccr  = merge16(channel_select_word, avs_writedata, avs_byteenable);
        ccs_pkg::IDX_RS03: next_rs03 = merge16(rs03, avs_writedata, avs_byteenable);
        ccs_pkg::IDX_RS47: next_rs47 = merge16(rs47, avs_writedata, avs_byteenable);
        ccs_pkg::IDX_ERR:  next_err  = merge16(err, avs_writedata, avs_byteenable);
        default:           next_err  = err;
      endcase
    end
  end

  // bus registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ack     <= 1'b0;
      ctrl    <= ccs_pkg::ccs_ctrl_s'(ccs_pkg::CSR_RESET[7:1]);
      channel_select_word     <= 16'h00FF;
      rs03    <= 16'h0000;
      rs47    <= 16'h0000;
      err     <= 16'h0000;
      rdata   <= 32'h0000_0000;
      fault_q <= 1'b1;
      led_q   <= 1'b0;
    end
    else
    begin
      ack     <= next_ack;
      ctrl    <= next_ctrl;
      channel_select_word     <= next_ccr;
      rs03    <= next_rs03;
      rs47    <= next_rs47;
      err     <= next_err;
      rdata   <= next_rdata;
      fault_q <= next_fault_q;
      led_q   <= next_led_q;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  ccs_pkg::ccs_state_e state, next_state;
  logic [2:0]         ch, next_ch;
  logic [2:0]         mode, next_mode;
  logic [7:0]         pend, next_pend;
  logic [26:0]        cnt, next_cnt;
  logic [26:0]        total, next_total;
  logic               next_active, next_stfail;
  logic               trig_q;
  logic signed [12:0] sample, next_sample;
  logic signed [12:0] offs [8];
  logic signed [12:0] next_offs [8];
  logic signed [13:0] gain [8];
  logic signed [13:0] next_gain [8];
  logic signed [15:0] next_ccd [8];
  logic               next_conv_start, next_nvm_we;
  logic [3:0]         next_nvm_addr;
  logic [15:0]        next_nvm_wdata;
  logic signed [31:0] s_diff, s_corr;
  logic               go, is_cal;
  logic [7:0]         rest;
  logic [31:0]        rs_all;

  assign rs_all = {rs47, rs03};
  assign is_cal = (mode == ccs_pkg::MODE_OFFS_CAL) || (mode == ccs_pkg::MODE_GAIN_CAL);
  assign rest   = pend & ~(8'h01 << ch);
  assign go = (wr_start | (ctrl.ext_trig_en & trig_q & ~external_trigger_input_n))
              & ~active & ~ctrl.sw_reset;

  // channel walk, settling, conversion and correction math
  always_comb
  begin
    next_state      = state;
    next_ch         = ch;
    next_mode       = mode;
    next_pend       = pend;
    next_cnt        = cnt;
    next_total      = active ? 27'(total + 27'h000_0001) : total;
    next_active     = active;
    next_stfail     = stfail;
    next_sample     = sample;
    next_offs       = offs;
    next_gain       = gain;
    next_ccd        = ccd;
    next_conv_start = 1'b0;
    next_nvm_we     = 1'b0;
    next_nvm_addr   = nvm_addr;
    next_nvm_wdata  = nvm_wdata;
    s_diff = 32'(sample) - 32'(offs[ch]);
    s_corr = s_diff + ((s_diff * 32'(gain[ch])) >>> ccs_pkg::GAIN_SHIFT);
    case (state)
      ccs_pkg::ST_IDLE:
        // only defined modes start a sequence
        // mode of the start write itself, so a single control word selects and starts
        if (go && (next_ctrl.mode == ccs_pkg::MODE_SINGLE
                   || next_ctrl.mode == ccs_pkg::MODE_CONT
                   || next_ctrl.mode == ccs_pkg::MODE_OFFS_CAL
                   || next_ctrl.mode == ccs_pkg::MODE_GAIN_CAL))
        begin
          next_active = 1'b1;
          next_mode   = next_ctrl.mode;
          next_total  = 27'h000_0000;
          next_cnt    = 27'h000_0000;
          next_pend   = channel_select_word[7:0];
          next_ch     = low_bit(channel_select_word[7:0]);
          next_state  = (channel_select_word[7:0] == 8'h00) ? ccs_pkg::ST_PAD : ccs_pkg::ST_SETTLE;
        end
      ccs_pkg::ST_SETTLE:
        if (cnt == SETTLE_LAST)
        begin
          next_conv_start = 1'b1;
          next_state      = ccs_pkg::ST_CONV;
        end
        else
          next_cnt = 27'(cnt + 27'h000_0001);
      ccs_pkg::ST_CONV:
        if (conv_done)
        begin
          next_sample = signed'(conv_data);
          next_state  = ccs_pkg::ST_STORE;
        end
      ccs_pkg::ST_STORE:
      begin
        if (mode == ccs_pkg::MODE_OFFS_CAL)
        begin
          next_offs[ch]  = sample;
          next_nvm_we    = 1'b1;
          next_nvm_addr  = {1'b0, ch};
          next_nvm_wdata = 16'(signed'(sample));
        end
        else if (mode == ccs_pkg::MODE_GAIN_CAL)
        begin
          next_gain[ch]  = 14'(32'(ccs_pkg::FULL_SCALE_CODE) - s_diff);
          next_nvm_we    = 1'b1;
          next_nvm_addr  = {1'b1, ch};
          next_nvm_wdata = 16'(32'(ccs_pkg::FULL_SCALE_CODE) - s_diff);
        end
        else
          next_ccd[ch] = s_corr[15:0];
        next_cnt  = 27'h000_0000;
        next_pend = rest;
        next_ch   = low_bit(rest);
        if (rest != 8'h00)
          next_state = ccs_pkg::ST_SETTLE;
        else if (is_cal)
          next_state = ccs_pkg::ST_PAD;
        else if (mode == ccs_pkg::MODE_CONT && ctrl.mode == ccs_pkg::MODE_CONT)
        begin
          next_pend  = channel_select_word[7:0];
          next_ch    = low_bit(channel_select_word[7:0]);
          next_state = (channel_select_word[7:0] == 8'h00) ? ccs_pkg::ST_IDLE : ccs_pkg::ST_SETTLE;
          next_active = (channel_select_word[7:0] != 8'h00);
        end
        else
        begin
          next_active = 1'b0;
          next_state  = ccs_pkg::ST_IDLE;
        end
      end
      ccs_pkg::ST_PAD:
        // hold flag for full calibration time in calibration modes; scan modes leave at once
        if (!is_cal || total >= CAL_LAST)
        begin
          next_active = 1'b0;
          next_state  = ccs_pkg::ST_IDLE;
        end
      ccs_pkg::ST_TEST:
        if (cnt == TEST_LAST)
        begin
          next_active = 1'b0;
          next_stfail = 1'b0;
          next_state  = ccs_pkg::ST_IDLE;
        end
        else
          next_cnt = 27'(cnt + 27'h000_0001);
      default:
        next_state = ccs_pkg::ST_IDLE;
    endcase
    // software reset holds flag and restarts self-test
    if (ctrl.sw_reset)
    begin
      next_state  = ccs_pkg::ST_TEST;
      next_cnt    = 27'h000_0000;
      next_active = 1'b1;
      next_stfail = 1'b1;
    end
  end

  // sequencer registers
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state      <= ccs_pkg::ST_TEST;
      ch         <= 3'h0;
      mode       <= 3'h0;
      pend       <= 8'h00;
      cnt        <= 27'h000_0000;
      total      <= 27'h000_0000;
      active     <= 1'b1;
      stfail     <= 1'b1;
      trig_q     <= 1'b1;
      sample     <= 13'sh0000;
      offs       <= '{default: 13'sh0000};
      gain       <= '{default: 14'sh0000};
      ccd        <= '{default: 16'sh0000};
      conv_start <= 1'b0;
      nvm_we     <= 1'b0;
      nvm_addr   <= 4'h0;
      nvm_wdata  <= 16'h0000;
    end
    else
    begin
      state      <= next_state;
      ch         <= next_ch;
      mode       <= next_mode;
      pend       <= next_pend;
      cnt        <= next_cnt;
      total      <= next_total;
      active     <= next_active;
      stfail     <= next_stfail;
      trig_q     <= external_trigger_input_n;
      sample     <= next_sample;
      offs       <= next_offs;
      gain       <= next_gain;
      ccd        <= next_ccd;
      conv_start <= next_conv_start;
      nvm_we     <= next_nvm_we;
      nvm_addr   <= next_nvm_addr;
      nvm_wdata  <= next_nvm_wdata;
    end
  end

  // range of current channel to front end
  assign afe_chan_sel = ch;
  assign afe_range    = rs_all[ch * ccs_pkg::RANGE_W +: ccs_pkg::RANGE_W];

endmodule

// *** tb/ccs_sequencer_sva.sv ***
// port assertions for the calibration sequencer
`timescale 1ns/100ps
module ccs_sequencer_sva #(
  parameter int unsigned SETTLE_CYCLES = 4
) (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic        avs_waitrequest,
  input wire logic        cal_switch,
  input wire logic        status_led,
  input wire logic        fault_led_on,
  input wire logic [2:0]  afe_chan_sel,
  input wire logic        conv_start,
  input wire logic        conv_done,
  input wire logic        nvm_we,
  input wire logic [3:0]  nvm_addr
);
  // ****************************************
  // shadow of host writes
  // ****************************************
  logic [7:0] mask;
  logic [2:0] mode;
  logic       f_exp;
  logic       pend;
  logic [3:0] since;
  logic       wr_ok;
  assign wr_ok = avs_write & ~avs_waitrequest;
  // mask, mode, indicator and gap since last conversion
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      mask  <= 8'hFF;
      mode  <= 3'h1;
      f_exp <= 1'b1;
      pend  <= 1'b0;
      since <= 4'hF;
    end
    else
    begin
      if (wr_ok && avs_address == 8'h20)
        mask <= avs_writedata[7:0];
      if (wr_ok && avs_address == 8'h08)
      begin
        mode  <= avs_writedata[3:1];
        f_exp <= ~avs_writedata[7];
      end
      pend  <= conv_done | (pend & ~conv_start);
      since <= conv_done ? 4'h0 : (since == 4'hF ? since : since + 4'h1);
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  sequence csr_wr_s;
    wr_ok && avs_address == 8'h08;
  endsequence
  sequence req_wait_s;
    (avs_read | avs_write) && avs_waitrequest;
  endsequence
  bus_wait_a: assert property (req_wait_s |=> !avs_waitrequest)
    else $error("wait state too long");
  settle_gap_a: assert property (conv_start |-> since >= SETTLE_CYCLES)
    else $error("conversion before settling");
  mask_only_a: assert property (conv_start |-> mask[afe_chan_sel])
    else $error("unmasked channel converted");
  cal_store_a: assert property (nvm_we |-> mode[2] && nvm_addr[3] == mode[0])
    else $error("store in wrong mode");
  store_after_a: assert property (nvm_we |-> pend)
    else $error("store without sample");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("long conversion request");
  store_pulse_a: assert property (nvm_we |=> !nvm_we)
    else $error("long store pulse");
  led_follow_a: assert property (##1 status_led == $past(cal_switch))
    else $error("status indicator wrong");
  fault_led_a: assert property (csr_wr_s |=> ##1 fault_led_on == f_exp)
    else $error("fault indicator wrong");
endmodule
bind ccs_sequencer ccs_sequencer_sva #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_sva (
  .clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .cal_switch(cal_switch),
  .status_led(status_led), .fault_led_on(fault_led_on),
  .afe_chan_sel(afe_chan_sel), .conv_start(conv_start), .conv_done(conv_done),
  .nvm_we(nvm_we), .nvm_addr(nvm_addr));

// *** tb/ccs_afe_model.sv ***
// converter front end answering conversion requests
`timescale 1ns/100ps
module ccs_afe_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        full,
  input  wire logic [3:0]  lat,
  input  wire logic [2:0]  chan,
  input  wire logic        start,
  output logic             done,
  output logic      [12:0] data
);
  logic [3:0] cnt;
  // small zero error per channel, span added at full scale
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt  <= 4'h0;
      done <= 1'b0;
      data <= 13'h0AAA;
    end
    else
    begin
      done <= cnt == 4'h1;
      data <= cnt == 4'h1 ? (full ? 13'(4000 + chan) : 13'(chan + 1)) : ~data;
      cnt  <= start ? lat : (cnt != 4'h0 ? cnt - 4'h1 : cnt);
    end
  end
endmodule

// *** tb/channel_calibration_sequencer_tb_top.sv ***
// self-checking bench for the calibration sequencer
`timescale 1ns/100ps
module channel_calibration_sequencer_tb_top;
  localparam int CAL = 200;
  logic        clk, nrst, avs_read, avs_write, avs_waitrequest, cal_switch;
  logic        status_led, fault_led_on, conv_start, conv_done, nvm_we, full;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  logic [3:0]  avs_byteenable, afe_range, nvm_addr, lat;
  logic [2:0]  afe_chan_sel;
  logic [12:0] conv_data;
  logic [15:0] nvm_wdata, rd;
  logic [3:0]  q_a[$];
  logic [15:0] q_d[$];
  int          n_fail, n_checks, cyc, t0;

  // id and revision values are arbitrary
  ccs_sequencer #(.CAL_CYCLES(CAL), .SETTLE_CYCLES(4), .SELFTEST_CYCLES(10),
    .BOARD_ID(16'hA5C3), .FW_REVISION(16'h0007)) dut (
    .clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest,
    .external_trigger_input_n(1'b1), .cal_switch, .status_led, .fault_led_on,
    .afe_chan_sel, .afe_range, .conv_start, .conv_done, .conv_data, .nvm_we,
    .nvm_addr, .nvm_wdata);
  ccs_afe_model afe (.clk, .nrst, .full, .lat, .chan(afe_chan_sel),
    .start(conv_start), .done(conv_done), .data(conv_data));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // cycle count and capture of stored factors
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (nvm_we === 1'b1)
    begin
      q_a.push_back(nvm_addr);
      q_d.push_back(nvm_wdata);
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // one access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= {16'h0000, d};
    avs_write     <= w;
    avs_read      <= ~w;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 9);
    rd = avs_readdata[15:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_waitrequest !== 1'b0)
    begin
      n_fail++;
    end
  endtask
  // poll the active flag until it clears
  task automatic idle();
    int n;
    n = 0;
    do
    begin
      bus(1'b0, 8'h08, 16'h0000);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 300);
    if (rd[0] !== 1'b0)
    begin
      n_fail++;
    end
  endtask
  // one calibration over mask m, every stored factor checked
  task automatic cal(input logic [15:0] control_status_word, input logic [7:0] m);
    int j;
    j = 0;
    q_a.delete();
    q_d.delete();
    full <= control_status_word[1];
    bus(1'b1, 8'h08, 16'h0080);
    bus(1'b1, 8'h20, {8'h00, m});
    bus(1'b1, 8'h08, control_status_word);
    t0 = cyc;
    bus(1'b0, 8'h08, 16'h0000);
    chk("active", rd, control_status_word);
    chk("fault", {15'h0000, fault_led_on}, 16'h0000);
    idle();
    chk("span", 16'(cyc - t0 >= CAL - 2 && cyc - t0 <= CAL + 10), 16'h0001);
    chk("count", 16'(q_a.size()), 16'($countones(m)));
    for (int c = 0; c < 8; c++)
      if (m[c])
      begin
        chk("addr", {12'h000, q_a[j]}, {12'h000, control_status_word[1], 3'(c)});
        chk("factor", q_d[j], control_status_word[1] ? 16'h0060 : 16'(c + 1));
        j++;
      end
    $display("test cal %h mask %h done", control_status_word, m);
  endtask

  initial
  begin
    logic [15:0] rsv [4] = '{16'h0085, 16'h0087, 16'h008D, 16'h008F};
    logic [7:0]  ra [4]  = '{8'h00, 8'h18, 8'h20, 8'h38};
    logic [15:0] re [4]  = '{16'hA5C3, 16'h0007, 16'h00FF, 16'h0000};
    n_fail = 0;
    n_checks = 0;
    nrst = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 8'h00;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h3;
    cal_switch = 1'b0;
    full = 1'b0;
    lat = 4'h1;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    bus(1'b0, 8'h08, 16'h0000);
    chk("selftest", rd, 16'h0043);
    chk("fault", {15'h0000, fault_led_on}, 16'h0001);
    idle();
    chk("csr", rd, 16'h0002);
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b0, ra[k], 16'h0000);
      chk("reg", rd, re[k]);
    end
    $display("test reset done");
    cal_switch <= 1'b1;
    repeat (2) @(posedge clk);
    chk("led", {15'h0000, status_led}, 16'h0001);
    bus(1'b1, 8'h28, 16'h2222);
    bus(1'b1, 8'h30, 16'h2222);
    cal(16'h0089, 8'h05);
    chk("range", {12'h000, afe_range}, 16'h0002);
    cal(16'h0089, 8'hFF);
    lat <= 4'h9;
    cal(16'h008B, 8'hFF);
    // single scan of channel 0 with stored factors applied
    q_a.delete();
    bus(1'b1, 8'h20, 16'h0001);
    bus(1'b1, 8'h08, 16'h0081);
    idle();
    bus(1'b0, 8'h40, 16'h0000);
    chk("scan", rd, 16'h0FFC);
    chk("nostore", 16'(q_a.size()), 16'h0000);
    $display("test scan done");
    // continuous scan keeps running until the mode is changed
    bus(1'b1, 8'h08, 16'h0083);
    repeat (40) @(posedge clk);
    bus(1'b0, 8'h08, 16'h0000);
    chk("cont", rd, 16'h0083);
    bus(1'b1, 8'h08, 16'h0080);
    idle();
    for (int k = 0; k < 4; k++)
    begin
      bus(1'b1, 8'h08, rsv[k]);
      bus(1'b0, 8'h08, 16'h0000);
      chk("reserved", rd, rsv[k] & 16'hFFFE);
    end
    // software reset holds the flag, then self-test runs again
    bus(1'b1, 8'h08, 16'h00A0);
    bus(1'b0, 8'h08, 16'h0000);
    chk("swreset", rd, 16'h00E1);
    bus(1'b1, 8'h08, 16'h0080);
    idle();
    chk("retest", rd, 16'h0080);
    cal_switch <= 1'b0;
    repeat (2) @(posedge clk);
    chk("led", {15'h0000, status_led}, 16'h0000);
    $display("test modes done");
    conclude();
  end
endmodule
